// *** core/adgc_pkg.sv ***
/*
 * Shared constants for the auxiliary DAC, GPIO and ADC register bank.
 * Assumes a byte-wide register port driven by the serial interface decoder.
 */
package adgc_pkg;

    // ************************************************************
    // Byte addresses
    // ************************************************************
    localparam logic [6:0] ADGC_DAC_LO_ADDR = 7'h30;
    localparam logic [6:0] ADGC_DAC_HI_ADDR = 7'h31;
    localparam logic [6:0] ADGC_PDL_LO_ADDR = 7'h32;
    localparam logic [6:0] ADGC_PDL_HI_ADDR = 7'h33;
    localparam logic [6:0] ADGC_ADC_LO_ADDR = 7'h3a;
    localparam logic [6:0] ADGC_ADC_HI_ADDR = 7'h3b;
    localparam logic [6:0] ADGC_CMD_LO_ADDR = 7'h3e;

    // ************************************************************
    // Field positions and widths
    // ************************************************************
    localparam int ADGC_DAC_W = 12;
    localparam int ADGC_ADC_W = 12;
    localparam int ADGC_LINES = 2;
    localparam int ADGC_CMD_DAC_LATCH_BIT = 2;
    localparam int ADGC_PDL_DIR_LSB = 0;
    localparam int ADGC_PDL_LVL_LSB = 8;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [15:0] ADGC_DAC_RESET = 16'h0000;
    localparam logic [15:0] ADGC_PDL_RESET = 16'h0000;
    localparam logic [11:0] ADGC_ADC_RESET = 12'h000;

endpackage

// *** core/adgc_dac_latch.sv ***
/*
 * Converter input latch: takes the holding register only on a latch command.
 * Assumes the caller pulses the latch request for one cycle.
 */
`timescale 1ns/10ps
module adgc_dac_latch
    import adgc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic latch_req,
    input wire logic [15:0] holding,
    output logic [ADGC_DAC_W-1:0] dac_code
);

    logic [ADGC_DAC_W-1:0] code_reg;
    logic [ADGC_DAC_W-1:0] code_next;

    // Upper four bits never reach the converter.
    always_comb begin
        code_next = code_reg;
        if (latch_req) begin
            code_next = holding[ADGC_DAC_W-1:0]; // [RULE2] [RULE3] [RULE4]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code_reg <= ADGC_DAC_RESET[ADGC_DAC_W-1:0];
        end else begin
            code_reg <= code_next;
        end
    end

    assign dac_code = code_reg;

endmodule

// *** core/adgc_gpio_arb.sv ***
/*
 * Per-line owner selection for the two general-purpose lines.
 * Assumes claims and levels from the other functions are synchronous.
 */
`timescale 1ns/10ps
module adgc_gpio_arb
    import adgc_pkg::*;
(
    input wire logic [ADGC_LINES-1:0] misc_claim,
    input wire logic [ADGC_LINES-1:0] misc_level,
    input wire logic [ADGC_LINES-1:0] alarm_claim,
    input wire logic [ADGC_LINES-1:0] alarm_level,
    input wire logic [ADGC_LINES-1:0] reg_dir,
    input wire logic [ADGC_LINES-1:0] reg_level,
    output logic [ADGC_LINES-1:0] drive,
    output logic [ADGC_LINES-1:0] level
);

    genvar i;
    generate
        for (i = 0; i < ADGC_LINES; i++) begin : g_line
            always_comb begin
                if (misc_claim[i]) begin // [RULE9]
                    drive[i] = 1'b1;
                    level[i] = misc_level[i];
                end else if (alarm_claim[i]) begin // [RULE9]
                    drive[i] = 1'b1;
                    level[i] = alarm_level[i];
                end else begin
                    drive[i] = reg_dir[i]; // [RULE6]
                    level[i] = reg_level[i]; // [RULE7]
                end
            end
        end
    endgenerate

endmodule

// *** core/adgc_top.sv ***
/*
 * Auxiliary DAC holding register, GPIO direction/level register and
 * auxiliary ADC result register behind a byte-wide register port.
 * Assumes the serial interface decoder presents one byte access per strobe,
 * with all inputs synchronous to clk.
 */
`timescale 1ns/10ps

//Operation
// [RULE1] DAC code arrives as two byte writes, assembled into one 16-bit holding register.
// [RULE2] Converter sees holding contents only when the latch command arrives.
// [RULE3] Writing one to command bit 2 latches holding register into converter.
// [RULE4] Only bits 11:0 form the unsigned code; bits 15:12 ignored.
// [RULE5] Holding register is read/write and cleared to zero on reset.
// [RULE6] Direction bits 0 and 1 select input (0) or output (1) per line.
// [RULE7] Level bits 8 and 9 set driven level; other bits unused.
// [RULE8] Direction/level register is read/write and cleared on reset, lines input.
// [RULE9] Line ownership: misc control first, then alarm, then direction/level register.
// [RULE10] ADC result reads as 12-bit unsigned straight binary.
// [RULE11] Input lines return the sampled pin level in their level bit on read.
module adgc_top
    import adgc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic [ADGC_DAC_W-1:0] dac_code,
    input wire logic adc_valid,
    input wire logic [ADGC_ADC_W-1:0] adc_result,
    input wire logic [ADGC_LINES-1:0] gpio_in,
    output logic [ADGC_LINES-1:0] gpio_out,
    output logic [ADGC_LINES-1:0] gpio_oe_n,
    input wire logic [ADGC_LINES-1:0] misc_control_claim,
    input wire logic [ADGC_LINES-1:0] misc_control_level,
    input wire logic [ADGC_LINES-1:0] alarm_control_claim,
    input wire logic [ADGC_LINES-1:0] alarm_control_level
);

    // ************************************************************
    // Register state
    // ************************************************************
    logic [15:0] dac_hold_reg;
    logic [15:0] dac_hold_next;
    logic [15:0] pdl_reg;
    logic [15:0] pdl_next;
    logic [ADGC_ADC_W-1:0] adc_reg;
    logic [ADGC_ADC_W-1:0] adc_next;
    logic latch_reg;
    logic latch_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [ADGC_LINES-1:0] gpio_out_reg;
    logic [ADGC_LINES-1:0] gpio_out_next;
    logic [ADGC_LINES-1:0] oe_n_reg;
    logic [ADGC_LINES-1:0] oe_n_next;
    logic [ADGC_LINES-1:0] arb_drive;
    logic [ADGC_LINES-1:0] arb_level;
    logic [15:0] pdl_view;

    // ************************************************************
    // Register writes
    // ************************************************************
    // Each byte lands on its own; the converter is untouched until the
    // latch command, so a half-written code never shows at the output.
    always_comb begin
        dac_hold_next = dac_hold_reg;
        pdl_next = pdl_reg;
        latch_next = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                ADGC_DAC_LO_ADDR: dac_hold_next[7:0] = reg_wdata; // [RULE1] [RULE5]
                ADGC_DAC_HI_ADDR: dac_hold_next[15:8] = reg_wdata; // [RULE1] [RULE5]
                ADGC_PDL_LO_ADDR: pdl_next[7:0] = reg_wdata; // [RULE6] [RULE8]
                ADGC_PDL_HI_ADDR: pdl_next[15:8] = reg_wdata; // [RULE7] [RULE8]
                ADGC_CMD_LO_ADDR: latch_next = reg_wdata[ADGC_CMD_DAC_LATCH_BIT]; // [RULE3]
                default: latch_next = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dac_hold_reg <= ADGC_DAC_RESET; // [RULE5]
            pdl_reg <= ADGC_PDL_RESET; // [RULE8]
            latch_reg <= 1'b0;
        end else begin
            dac_hold_reg <= dac_hold_next;
            pdl_reg <= pdl_next;
            latch_reg <= latch_next;
        end
    end

    // ************************************************************
    // Converter input
    // ************************************************************
    adgc_dac_latch u_dac_latch (
        .clk(clk),
        .rst(rst),
        .latch_req(latch_reg),
        .holding(dac_hold_reg),
        .dac_code(dac_code)
    );

    // ************************************************************
    // Auxiliary ADC result
    // ************************************************************
    always_comb begin
        adc_next = adc_reg;
        if (adc_valid) begin
            adc_next = adc_result; // [RULE10]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            adc_reg <= ADGC_ADC_RESET;
        end else begin
            adc_reg <= adc_next;
        end
    end

    // ************************************************************
    // Line ownership and pin drivers
    // ************************************************************
    adgc_gpio_arb u_gpio_arb (
        .misc_claim(misc_control_claim),
        .misc_level(misc_control_level),
        .alarm_claim(alarm_control_claim),
        .alarm_level(alarm_control_level),
        .reg_dir(pdl_reg[ADGC_PDL_DIR_LSB +: ADGC_LINES]),
        .reg_level(pdl_reg[ADGC_PDL_LVL_LSB +: ADGC_LINES]),
        .drive(arb_drive),
        .level(arb_level)
    );

    // Pin drivers are registered so the outputs never glitch on arbitration.
    always_comb begin
        gpio_out_next = arb_level;
        oe_n_next = ~arb_drive;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gpio_out_reg <= '0;
            oe_n_reg <= '1;
        end else begin
            gpio_out_reg <= gpio_out_next;
            oe_n_reg <= oe_n_next;
        end
    end

    assign gpio_out = gpio_out_reg;
    assign gpio_oe_n = oe_n_reg;

    // ************************************************************
    // Register reads
    // ************************************************************
    // Lines set to input report the pin; lines set to output report the
    // stored level, so software sees what it asked for.
    always_comb begin
        pdl_view = pdl_reg;
        for (int i = 0; i < ADGC_LINES; i++) begin
            if (!pdl_reg[ADGC_PDL_DIR_LSB + i]) begin
                pdl_view[ADGC_PDL_LVL_LSB + i] = gpio_in[i]; // [RULE11]
            end
        end
    end

    always_comb begin
        rdata_next = rdata_reg;
        if (reg_rd) begin
            case (reg_addr)
                ADGC_DAC_LO_ADDR: rdata_next = dac_hold_reg[7:0]; // [RULE5]
                ADGC_DAC_HI_ADDR: rdata_next = dac_hold_reg[15:8]; // [RULE5]
                ADGC_PDL_LO_ADDR: rdata_next = pdl_view[7:0]; // [RULE8]
                ADGC_PDL_HI_ADDR: rdata_next = pdl_view[15:8]; // [RULE8]
                ADGC_ADC_LO_ADDR: rdata_next = adc_reg[7:0]; // [RULE10]
                ADGC_ADC_HI_ADDR: rdata_next = {4'h0, adc_reg[11:8]}; // [RULE10]
                default: rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule

// *** testbench/adgc_assertions.sv ***
/* Port checker for adgc_top.
   Bound to every adgc_top; sees its ports only. */
`timescale 1ns/10ps
module adgc_chk
    import adgc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [ADGC_DAC_W-1:0] dac_code,
    input wire logic adc_valid,
    input wire logic [ADGC_ADC_W-1:0] adc_result,
    input wire logic [ADGC_LINES-1:0] gpio_out,
    input wire logic [ADGC_LINES-1:0] gpio_oe_n,
    input wire logic [ADGC_LINES-1:0] misc_control_claim,
    input wire logic [ADGC_LINES-1:0] misc_control_level,
    input wire logic [ADGC_LINES-1:0] alarm_control_claim,
    input wire logic [ADGC_LINES-1:0] alarm_control_level
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);
    logic latch;
    logic [7:0] adc_lo;
    logic [1:0] alarm_only;
    assign latch = reg_wr && reg_addr == ADGC_CMD_LO_ADDR && reg_wdata[2];
    assign adc_lo = adc_result[7:0];
    assign alarm_only = alarm_control_claim & ~misc_control_claim;
    dac_hold_a: assert property (!$past(latch, 2) |-> $stable(dac_code))
        else $error("dac code moved without latch");
    misc_drive_a: assert property (1 |=> (gpio_oe_n & $past(misc_control_claim)) == 2'h0)
        else $error("misc claimed line not driven");
    misc_level_a: assert property (1 |=>
        ((gpio_out ^ $past(misc_control_level)) & $past(misc_control_claim)) == 2'h0)
        else $error("misc level not on line");
    alarm_prio_a: assert property (1 |=> ((gpio_oe_n & $past(alarm_only)) == 2'h0) &&
        ((gpio_out ^ $past(alarm_control_level)) & $past(alarm_only)) == 2'h0)
        else $error("alarm line wrong");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
    cmd_read_a: assert property (reg_rd && reg_addr == ADGC_CMD_LO_ADDR |=> reg_rdata == 8'h00)
        else $error("command register read not zero");
    adc_hi_a: assert property (reg_rd && reg_addr == ADGC_ADC_HI_ADDR |=> reg_rdata[7:4] == 4'h0)
        else $error("adc high nibble not zero");
    adc_lo_a: assert property (adc_valid ##1 (reg_rd && reg_addr == ADGC_ADC_LO_ADDR &&
        !adc_valid) |=> reg_rdata == $past(adc_lo, 2))
        else $error("adc low byte wrong");
    rst_init_a: assert property ($fell(rst) |-> gpio_oe_n == 2'h3 && dac_code == 12'h000)
        else $error("state after reset wrong");
endmodule
bind adgc_top adgc_chk chk (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dac_code(dac_code),
    .adc_valid(adc_valid), .adc_result(adc_result), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
    .misc_control_claim(misc_control_claim), .misc_control_level(misc_control_level),
    .alarm_control_claim(alarm_control_claim), .alarm_control_level(alarm_control_level));

// *** testbench/adgc_host_model.sv ***
/* Host byte master for the register port.
   Tasks are entered just after a rising clk edge. */
`timescale 1ns/10ps
module adgc_host_model
(
    input wire logic clk,
    output logic reg_wr,
    output logic reg_rd,
    output logic [6:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
    end
    // One strobe per byte, so 16-bit values take two calls.
    task automatic write_byte(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic read_byte(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        reg_rd = 1'b0;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask
endmodule

// *** testbench/tb_top.sv ***
/* Self-checking bench for adgc_top with an integer model.
   Uses the host model for every register access. */
`timescale 1ns/10ps
module tb_top;
    import adgc_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic adc_valid = 1'b0;
    logic reg_wr, reg_rd;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rb;
    logic [11:0] dac_code;
    logic [11:0] adc_result = 12'h000;
    logic [1:0] gpio_out, gpio_oe_n;
    logic [1:0] gpio_in = 2'h0, mc = 2'h0, ml = 2'h0, ac = 2'h0, al = 2'h0;
    int err_count = 0, checks_done = 0, hold, dac, pdl, dir, lvl, drv, eo;
    always #50 clk = ~clk;
    adgc_host_model host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    adgc_top uut (.clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .dac_code(dac_code), .adc_valid(adc_valid),
        .adc_result(adc_result), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
        .misc_control_claim(mc), .misc_control_level(ml),
        .alarm_control_claim(ac), .alarm_control_level(al));
    task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic check_dac(input logic [11:0] exp);
        checks_done++;
        if (dac_code !== exp) begin
            err_count++;
            $display("unexpected at %0t: dac got %h expected %h", $time, dac_code, exp);
        end
    endtask
    task automatic check_pin(input logic [1:0] got, input logic [1:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: pins got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Reset again at the end of the run, since stale holding bytes must not survive it.
    task automatic reset_and_check();
        rst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        rst = 1'b0;
        dac = 0;
        for (int a = 0; a < 4; a++) begin
            host.read_byte(ADGC_DAC_LO_ADDR + 7'(a), rb);
            // Both lines are inputs after reset, so the level byte shows the pins.
            check_val(16'(rb), (a == 3) ? 16'(gpio_in) : 16'h0000);
        end
        check_dac(12'h000);
    endtask
    initial begin
        void'($urandom(92));
        reset_and_check();
        for (int i = 0; i < 6; i++) begin
            hold = (i == 0) ? 'hffff : int'($urandom_range(16'hffff));
            host.write_byte(ADGC_DAC_LO_ADDR, 8'(hold));
            host.write_byte(ADGC_DAC_HI_ADDR, 8'(hold >> 8));
            host.read_byte(ADGC_DAC_LO_ADDR, rb);
            check_val(16'(rb), 16'(hold & 'hff));
            host.read_byte(ADGC_DAC_HI_ADDR, rb);
            check_val(16'(rb), 16'(hold >> 8));
            host.write_byte(ADGC_CMD_LO_ADDR, 8'($urandom) & 8'hfb);
            repeat (2) @(posedge clk);
            #1;
            check_dac(12'(dac));
            host.write_byte(ADGC_CMD_LO_ADDR, 8'h04);
            repeat (2) @(posedge clk);
            #1;
            dac = hold & 'hfff;
            check_dac(12'(dac));
        end
        host.read_byte(ADGC_CMD_LO_ADDR, rb);
        check_val(16'(rb), 16'h0000);
        for (int i = 0; i < 12; i++) begin
            {mc, ml, ac, al, gpio_in} = 10'($urandom);
            pdl = int'($urandom_range(16'hffff));
            host.write_byte(ADGC_PDL_LO_ADDR, 8'(pdl));
            host.write_byte(ADGC_PDL_HI_ADDR, 8'(pdl >> 8));
            repeat (2) @(posedge clk);
            #1;
            dir = pdl & 3;
            lvl = (pdl >> 8) & 3;
            drv = int'(mc | ac) | dir;
            eo = int'(mc & ml) | int'(~mc & ac & al) | (int'(~(mc | ac)) & dir & lvl);
            check_pin(gpio_oe_n, 2'(~drv));
            check_pin(gpio_out & 2'(drv), 2'(eo));
            host.read_byte(ADGC_PDL_LO_ADDR, rb);
            check_val(16'(rb & 8'h03), 16'(dir));
            host.read_byte(ADGC_PDL_HI_ADDR, rb);
            check_val(16'(rb & 8'h03), 16'((dir & lvl) | (~dir & int'(gpio_in) & 3)));
        end
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            #1;
            adc_result = 12'($urandom);
            adc_valid = 1'b1;
            adc_valid <= #100 1'b0;
            host.read_byte(ADGC_ADC_LO_ADDR, rb);
            check_val(16'(rb), 16'(adc_result & 12'h0ff));
            host.read_byte(ADGC_ADC_HI_ADDR, rb);
            check_val(16'(rb), 16'(adc_result >> 8));
        end
        reset_and_check();
        final_report();
    end
endmodule
